// ### pkg/psg_pkg.sv
`default_nettype none
package psg_pkg;
    localparam int unsigned     MAC_W          = 48;
    localparam int unsigned     CNT_W          = 8;
    localparam int unsigned     POOL_W         = 11;
    localparam int unsigned     VCNT_W         = 16;
    localparam logic [CNT_W-1:0] LIMIT_MAX     = 8'h84;
    localparam logic [CNT_W-1:0] LIMIT_DEFAULT = 8'h01;
    localparam int unsigned     ENTRY_MAX      = int'(LIMIT_MAX);
    localparam logic [POOL_W:0] POOL_SIZE      = 12'h0400;
    localparam int unsigned     FIFO_DEPTH     = 16;
    localparam int unsigned     DESC_W         = MAC_W + 2;
    localparam int unsigned     DESC_VOICE_BIT = 1;
    localparam int unsigned     DESC_OTHER_BIT = 0;
    localparam logic [VCNT_W-1:0] VCNT_RST     = 16'h0000;
    localparam logic [VCNT_W-1:0] VCNT_MAX     = 16'hffff;
    localparam logic [CNT_W-1:0]  COUNT_RST    = 8'h00;

    typedef enum logic [1:0] {
        PSG_MODE_SHUTDOWN = 2'h0,
        PSG_MODE_PROTECT  = 2'h1,
        PSG_MODE_RESTRICT = 2'h2
    } psg_mode_t;

    typedef enum logic [1:0] {
        PSG_KIND_DYNAMIC = 2'h0,
        PSG_KIND_STATIC  = 2'h1,
        PSG_KIND_STICKY  = 2'h2
    } psg_kind_t;

    typedef enum logic [2:0] {
        PSG_OP_ADD_STATIC      = 3'h0,
        PSG_OP_ADD_STICKY      = 3'h1,
        PSG_OP_DEL_STICKY_ADDR = 3'h2,
        PSG_OP_DEL_STICKY_PORT = 3'h3,
        PSG_OP_DEL_DYNAMIC     = 3'h4
    } psg_op_t;

    typedef enum logic {
        PSG_ST_FORWARD = 1'b0,
        PSG_ST_ERRDIS  = 1'b1
    } psg_state_t;
endpackage : psg_pkg
`default_nettype wire

// ### pkg/psg_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psg_fifo_if #(parameter int W = 8) ();
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface : psg_fifo_if
`default_nettype wire

// ### rtl/psg_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module psg_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    psg_fifo_if.fifo q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          not_full_r;
    logic          not_empty_r;
    logic          push;
    logic          pop;

    assign push        = q.in_valid & not_full_r;
    assign pop         = q.out_ready & not_empty_r;
    assign q.in_ready  = not_full_r;
    assign q.out_valid = not_empty_r;
    assign q.out_data  = mem[rd_ptr_r];

    always_comb begin
        case ({push, pop})
            2'b10:   cnt_nxt = cnt_r + 1'b1;
            2'b01:   cnt_nxt = cnt_r - 1'b1;
            default: cnt_nxt = cnt_r;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= q.in_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            cnt_r       <= '0;
            not_full_r  <= 1'b1;
            not_empty_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            cnt_r       <= cnt_nxt;
            not_full_r  <= (cnt_nxt != DEPTH_C);
            not_empty_r <= (cnt_nxt != '0);
        end
    end

    a_fifo_full_flag: assert property (@(posedge core_clk) disable iff (rst)
        (cnt_r == DEPTH_C) |-> !q.in_ready)
        else $error("fifo accepts while full");
endmodule : psg_fifo
`default_nettype wire

// ### rtl/psg_guard.sv
`timescale 1ns/1ps
`default_nettype none
module psg_guard
    import psg_pkg::*;
#(
    parameter int N_ENTRIES = ENTRY_MAX,
    parameter int Q_DEPTH   = FIFO_DEPTH
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              frm_valid,
    output logic                   frm_ready,
    input  wire logic [MAC_W-1:0]  frm_mac,
    input  wire logic              frm_voice,
    input  wire logic              frm_other_hit,
    input  wire logic              cfg_guard_en,
    input  wire logic [CNT_W-1:0]  cfg_limit,
    input  wire logic [1:0]        cfg_mode,
    input  wire logic              cfg_sticky_en,
    input  wire logic              port_is_trunk,
    input  wire logic              port_is_dynamic,
    input  wire logic              port_is_traffic_mirror_destination,
    input  wire logic              port_is_lag_member,
    input  wire logic              admin_down,
    input  wire logic              recovery_en,
    input  wire logic              recovery_req,
    input  wire logic [POOL_W-1:0] pool_used_other,
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [MAC_W-1:0]  cmd_mac,
    input  wire logic              cmd_voice,
    output logic                   cmd_done,
    output logic                   cmd_refused,
    output logic                   fwd_valid,
    output logic [MAC_W-1:0]       fwd_mac,
    output logic                   fwd_voice,
    output logic                   drop_pulse,
    output logic                   notify_pulse,
    output logic [VCNT_W-1:0]      viol_count,
    output logic                   err_disabled,
    output logic                   port_led,
    output logic                   guard_active,
    output logic                   voice_guard_active,
    output logic                   guard_refused,
    output logic [CNT_W-1:0]       entry_count
);
    localparam int IDX_W = $clog2(N_ENTRIES);

    psg_fifo_if #(.W(DESC_W)) frm_q ();

    psg_fifo #(.W(DESC_W), .DEPTH(Q_DEPTH)) u_frm_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .q        (frm_q.fifo)
    );

    logic [N_ENTRIES-1:0] valid_r;
    psg_kind_t            kind_r  [N_ENTRIES];
    logic [MAC_W-1:0]     mac_r   [N_ENTRIES];
    logic [N_ENTRIES-1:0] voice_r;
    logic                 sticky_q_r;
    logic                 admin_q_r;
    psg_state_t           state_r;
    psg_state_t           state_nxt;
    logic [VCNT_W-1:0]    viol_cnt_r;

    logic [MAC_W-1:0]     f_mac;
    logic                 f_voice;
    logic                 f_other;
    logic                 pop;
    logic                 eligible;
    logic                 active;
    logic [CNT_W-1:0]     lim;
    logic [CNT_W-1:0]     cnt;
    logic [POOL_W:0]      pool_sum;
    logic                 at_limit;
    logic                 pool_full;
    logic [IDX_W:0]       look_f;
    logic [IDX_W:0]       look_c;
    logic [IDX_W:0]       free_s;
    logic                 viol;
    logic                 learn;
    logic                 pass;
    logic                 cmd_add;
    logic                 add_ok;
    logic                 cmd_ok;
    logic                 wr_en;
    logic [IDX_W-1:0]     wr_idx;
    psg_kind_t            wr_kind;
    logic                 sticky_rise;
    logic                 sticky_fall;
    logic                 readmit;
    logic                 do_notify;
    logic                 do_count;
    logic                 do_shut;

    function automatic logic [CNT_W-1:0] clamp_limit(input logic [CNT_W-1:0] v);
        if (v == '0) begin
            return LIMIT_DEFAULT;
        end else if (v > LIMIT_MAX) begin
            return LIMIT_MAX;
        end
        return v;
    endfunction : clamp_limit

    // returns {hit, index}; entries are keyed by address and VLAN together
    function automatic logic [IDX_W:0] find(input logic [MAC_W-1:0] m, input logic vc);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = N_ENTRIES - 1; i >= 0; i--) begin
            if (valid_r[i] && mac_r[i] == m && voice_r[i] == vc) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction : find

    function automatic logic [IDX_W:0] first_free();
        logic [IDX_W:0] r;
        r = '0;
        for (int i = N_ENTRIES - 1; i >= 0; i--) begin
            if (!valid_r[i]) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction : first_free

    function automatic logic [CNT_W-1:0] popcount(input logic [N_ENTRIES-1:0] v);
        logic [CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < N_ENTRIES; i++) begin
            c = c + CNT_W'(v[i]);
        end
        return c;
    endfunction : popcount

    assign frm_q.in_valid  = frm_valid;
    assign frm_q.in_data   = {frm_mac, frm_voice, frm_other_hit};
    assign frm_ready       = frm_q.in_ready;
    // commands own the table for their cycle, so frames wait in the queue
    assign frm_q.out_ready = ~cmd_valid;

    assign f_mac    = frm_q.out_data[DESC_W-1 -: MAC_W];
    assign f_voice  = frm_q.out_data[DESC_VOICE_BIT];
    assign f_other  = frm_q.out_data[DESC_OTHER_BIT];
    assign pop      = frm_q.out_valid & ~cmd_valid;

    assign eligible = ~(port_is_trunk | port_is_dynamic |
                        port_is_traffic_mirror_destination | port_is_lag_member);
    assign active   = cfg_guard_en & eligible;
    assign lim      = clamp_limit(cfg_limit);
    assign cnt      = popcount(valid_r);
    assign pool_sum = {1'b0, pool_used_other} + (POOL_W+1)'(cnt);
    assign at_limit = (cnt >= lim);
    assign pool_full = (pool_sum >= POOL_SIZE) | ~free_s[IDX_W];
    // a process, not assigns: the lookups read the table from inside functions
    always_comb begin
        look_f = find(f_mac, f_voice);
        look_c = find(cmd_mac, cmd_voice);
        free_s = first_free();
    end

    // violations only while forwarding; an error-disabled port drops every frame while the guard is active
    assign viol  = pop & active & (state_r == PSG_ST_FORWARD) &
                   (f_other | (~look_f[IDX_W] & at_limit));
    assign learn = pop & active & (state_r == PSG_ST_FORWARD) & ~f_other &
                   ~look_f[IDX_W] & ~at_limit & ~pool_full;
    assign pass  = pop & (~active | ((state_r == PSG_ST_FORWARD) & ~f_other &
                   (look_f[IDX_W] | learn)));

    assign cmd_add = cmd_valid & ((cmd_op == PSG_OP_ADD_STATIC) | (cmd_op == PSG_OP_ADD_STICKY));
    // an address already held is reclassified in place and needs no room
    assign add_ok  = cmd_add & ~cmd_voice & (look_c[IDX_W] | (~at_limit & ~pool_full));
    assign cmd_ok  = add_ok | (cmd_valid & ~cmd_add & (cmd_op <= PSG_OP_DEL_DYNAMIC));

    assign sticky_rise = cfg_sticky_en & ~sticky_q_r;
    assign sticky_fall = ~cfg_sticky_en & sticky_q_r;
    assign readmit     = admin_q_r & ~admin_down;

    always_comb begin
        wr_en   = 1'b0;
        wr_idx  = free_s[IDX_W-1:0];
        wr_kind = PSG_KIND_DYNAMIC;
        if (add_ok) begin
            wr_en   = 1'b1;
            wr_idx  = look_c[IDX_W] ? look_c[IDX_W-1:0] : free_s[IDX_W-1:0];
            wr_kind = (cmd_op == PSG_OP_ADD_STICKY) ? PSG_KIND_STICKY : PSG_KIND_STATIC;
        end else if (learn) begin
            wr_en   = 1'b1;
            wr_kind = (f_voice | ~cfg_sticky_en) ? PSG_KIND_DYNAMIC : PSG_KIND_STICKY;
        end
    end

    always_comb begin
        do_notify = 1'b0;
        do_count  = 1'b0;
        do_shut   = 1'b0;
        case (psg_mode_t'(cfg_mode))
            PSG_MODE_PROTECT: begin
                do_notify = 1'b0;
            end
            PSG_MODE_RESTRICT: begin
                do_notify = viol;
                do_count  = viol;
            end
            default: begin
                do_notify = viol;
                do_count  = viol;
                do_shut   = viol;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PSG_ST_FORWARD: begin
                if (do_shut) begin
                    state_nxt = PSG_ST_ERRDIS;
                end
            end
            PSG_ST_ERRDIS: begin
                if ((recovery_en & recovery_req) | readmit) begin
                    state_nxt = PSG_ST_FORWARD;
                end
            end
            default: begin
                state_nxt = PSG_ST_FORWARD;
            end
        endcase
    end

    // no aging path exists here, so sticky entries leave only by command
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            valid_r <= '0;
            for (int i = 0; i < N_ENTRIES; i++) begin
                kind_r[i] <= PSG_KIND_DYNAMIC;
            end
        end else begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                if (sticky_rise && kind_r[i] == PSG_KIND_DYNAMIC && !voice_r[i]) begin
                    kind_r[i] <= PSG_KIND_STICKY;
                end
                if (sticky_fall && kind_r[i] == PSG_KIND_STICKY) begin
                    kind_r[i] <= PSG_KIND_DYNAMIC;
                end
                if (cmd_valid && cmd_op == PSG_OP_DEL_DYNAMIC && kind_r[i] == PSG_KIND_DYNAMIC) begin
                    valid_r[i] <= 1'b0;
                end
                if (cmd_valid && cmd_op == PSG_OP_DEL_STICKY_PORT && kind_r[i] == PSG_KIND_STICKY) begin
                    valid_r[i] <= 1'b0;
                end
            end
            if (cmd_valid && cmd_op == PSG_OP_DEL_STICKY_ADDR && look_c[IDX_W] &&
                kind_r[look_c[IDX_W-1:0]] == PSG_KIND_STICKY) begin
                valid_r[look_c[IDX_W-1:0]] <= 1'b0;
            end
            if (wr_en) begin
                valid_r[wr_idx] <= 1'b1;
                kind_r[wr_idx]  <= wr_kind;
            end
        end
    end

    // address storage carries no reset; valid bits guard it
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mac_r[wr_idx]   <= add_ok ? cmd_mac : f_mac;
            voice_r[wr_idx] <= add_ok ? cmd_voice : f_voice;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sticky_q_r <= 1'b0;
            admin_q_r  <= 1'b0;
            state_r    <= PSG_ST_FORWARD;
        end else begin
            sticky_q_r <= cfg_sticky_en;
            admin_q_r  <= admin_down;
            state_r    <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            viol_cnt_r <= VCNT_RST;
        end else if (do_count && viol_cnt_r != VCNT_MAX) begin
            viol_cnt_r <= viol_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fwd_valid    <= 1'b0;
            fwd_mac      <= '0;
            fwd_voice    <= 1'b0;
            drop_pulse   <= 1'b0;
            notify_pulse <= 1'b0;
        end else begin
            fwd_valid    <= pass;
            fwd_mac      <= f_mac;
            fwd_voice    <= f_voice;
            drop_pulse   <= pop & ~pass;
            notify_pulse <= do_notify;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_done           <= 1'b0;
            cmd_refused        <= 1'b0;
            guard_active       <= 1'b0;
            voice_guard_active <= 1'b0;
            guard_refused      <= 1'b0;
            entry_count        <= COUNT_RST;
            err_disabled       <= 1'b0;
            port_led           <= 1'b1;
            viol_count         <= VCNT_RST;
        end else begin
            cmd_done           <= cmd_valid;
            cmd_refused        <= cmd_valid & ~cmd_ok;
            guard_active       <= active;
            voice_guard_active <= active;
            guard_refused      <= cfg_guard_en & ~eligible;
            entry_count        <= cnt;
            err_disabled       <= (state_nxt == PSG_ST_ERRDIS);
            port_led           <= (state_nxt == PSG_ST_FORWARD);
            viol_count         <= (do_count && viol_cnt_r != VCNT_MAX) ? viol_cnt_r + 1'b1 : viol_cnt_r;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_viol_mode(psg_mode_t m);
        viol && psg_mode_t'(cfg_mode) == m;
    endsequence

    a_protect_silent: assert property (s_viol_mode(PSG_MODE_PROTECT) |=>
        drop_pulse && !notify_pulse && $stable(viol_count))
        else $error("protect mode notified or counted");
    a_restrict_counts: assert property ((s_viol_mode(PSG_MODE_RESTRICT) && viol_cnt_r != VCNT_MAX) |=>
        drop_pulse && notify_pulse && viol_count == $past(viol_cnt_r) + 1'b1)
        else $error("restrict mode missed notify or count");
    a_shutdown_errdis: assert property (s_viol_mode(PSG_MODE_SHUTDOWN) |=>
        err_disabled && !port_led && notify_pulse)
        else $error("shutdown mode did not error-disable");
    a_default_shutdown: assert property ((viol && cfg_mode == 2'h3) |=> err_disabled)
        else $error("unselected mode code not shutdown");
    a_errdis_holds: assert property ((state_r == PSG_ST_ERRDIS && !(recovery_en && recovery_req) && !readmit)
        |=> err_disabled [*1] ##1 1'b1)
        else $error("error-disable left without cause");
    a_full_refused: assert property ((cmd_add && at_limit && !look_c[IDX_W]) |=>
        cmd_refused && $stable(valid_r))
        else $error("install accepted at limit");
    a_voice_refused: assert property ((cmd_add && cmd_voice) |=> cmd_refused)
        else $error("install on voice VLAN accepted");
    a_inactive_forwards: assert property ((pop && !active) |=> fwd_valid && !notify_pulse)
        else $error("inactive guard filtered a frame");
    a_ineligible_off: assert property ((cfg_guard_en && port_is_trunk) |=> !guard_active && guard_refused)
        else $error("guard active on trunk port");
    a_count_bound: assert property (cnt <= lim || $past(cnt) > lim || $changed(cfg_limit))
        else $error("entry count passed limit");
    a_sticky_convert: assert property ((sticky_rise && valid_r[0] && kind_r[0] == PSG_KIND_DYNAMIC && !voice_r[0])
        |=> kind_r[0] == PSG_KIND_STICKY)
        else $error("dynamic entry not made sticky");
endmodule : psg_guard
`default_nettype wire

// ### dv/psg_station_model.sv
`timescale 1ns/1ps
`default_nettype none
module psg_station_model (
    input  wire logic   core_clk,
    input  wire logic   frm_ready,
    output logic        frm_valid,
    output logic [47:0] frm_mac,
    output logic        frm_voice,
    output logic        frm_other_hit
);
    initial begin
        frm_valid = 1'b0;
        frm_mac = 48'h0000_0000_0000;
        frm_voice = 1'b0;
        frm_other_hit = 1'b0;
    end
    // held until ready is seen at an edge; released lines show the inverse, not a stale copy
    task automatic send(input logic [47:0] mac, input logic voice, input logic other);
        @(posedge core_clk);
        #2;
        frm_valid = 1'b1;
        frm_mac = mac;
        frm_voice = voice;
        frm_other_hit = other;
        @(posedge core_clk iff frm_ready);
        #2;
        frm_valid = 1'b0;
        frm_mac = ~mac;
        frm_voice = ~voice;
        frm_other_hit = ~other;
    endtask : send
endmodule : psg_station_model
`default_nettype wire

// ### dv/psg_guard_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module psg_guard_tb_top;
    import psg_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_guard_en, cfg_sticky_en, admin_down, cmd_valid, cmd_voice, cmd_done, cmd_refused;
    logic [CNT_W-1:0] cfg_limit, entry_count;
    logic [1:0] cfg_mode;
    logic [3:0] inel;
    logic [2:0] cmd_op;
    logic [MAC_W-1:0] cmd_mac, frm_mac, fwd_mac;
    logic frm_valid, frm_ready, frm_voice, frm_other_hit, fwd_valid, fwd_voice, drop_pulse, notify_pulse;
    logic err_disabled, port_led, guard_active, voice_guard_active, guard_refused;
    logic [VCNT_W-1:0] viol_count;
    int error_cnt = 0;
    int tests_run = 0;
    logic stim_voice = 1'b0;
    logic rec_en = 1'b0;
    logic rec_req = 1'b0;
    logic [POOL_W-1:0] pool_other = 11'h000;
    always #50 core_clk = ~core_clk;
    psg_guard #(.N_ENTRIES(4)) dut_u (.core_clk, .rst, .frm_valid, .frm_ready, .frm_mac, .frm_voice,
        .frm_other_hit, .cfg_guard_en, .cfg_limit, .cfg_mode, .cfg_sticky_en, .port_is_trunk(inel[0]),
        .port_is_dynamic(inel[1]), .port_is_traffic_mirror_destination(inel[2]), .port_is_lag_member(inel[3]),
        .admin_down, .recovery_en(rec_en), .recovery_req(rec_req), .pool_used_other(pool_other), .cmd_valid, .cmd_op,
        .cmd_mac, .cmd_voice, .cmd_done, .cmd_refused, .fwd_valid, .fwd_mac, .fwd_voice, .drop_pulse,
        .notify_pulse, .viol_count, .err_disabled, .port_led, .guard_active, .voice_guard_active,
        .guard_refused, .entry_count);
    psg_station_model stn_u (.core_clk, .frm_ready, .frm_valid, .frm_mac, .frm_voice, .frm_other_hit);
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : cyc
    task automatic frame(input logic [47:0] mac, input logic other, input logic fwd, input logic ntf);
        stn_u.send(mac, stim_voice, other);
        for (int i = 0; i < 8 && !(fwd_valid === 1'b1 || drop_pulse === 1'b1); i++) begin
            @(posedge core_clk);
            #2;
        end
        chk(fwd_valid, fwd);
        chk(drop_pulse, !fwd);
        chk(notify_pulse, ntf);
        if (fwd) begin
            chk(fwd_mac, mac);
            chk(fwd_voice, stim_voice);
        end
    endtask : frame
    task automatic cmd(input logic [2:0] op, input logic [47:0] mac, input logic voice, input logic refd);
        cmd_op = op;
        cmd_mac = mac;
        cmd_voice = voice;
        cmd_valid = 1'b1;
        cyc(1);
        cmd_valid = 1'b0;
        chk(cmd_done, 1'b1);
        chk(cmd_refused, refd);
        cyc(1);
    endtask : cmd
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #1_000_000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {cfg_guard_en, cfg_sticky_en, admin_down, cmd_valid, cmd_voice} = 5'h00;
        cfg_limit = 8'h00;
        cfg_mode = 2'h1;
        inel = 4'h0;
        cmd_op = 3'h0;
        cmd_mac = 48'h0000_0000_0000;
        cyc(16);
        rst = 1'b0;
        chk({guard_active, err_disabled, port_led, entry_count, viol_count}, 48'h0000_0100_0000);
        frame(48'h0a0a_0000_0001, 1'b0, 1'b1, 1'b0);
        cfg_guard_en = 1'b1;
        cyc(2);
        chk({guard_active, voice_guard_active}, 2'b11);
        frame(48'h0a0a_0000_0001, 1'b0, 1'b1, 1'b0);
        cyc(1);
        chk(entry_count, 8'h01);
        frame(48'h0a0a_0000_0002, 1'b0, 1'b0, 1'b0);
        chk(viol_count, 16'h0000);
        cfg_mode = 2'h2;
        frame(48'h0a0a_0000_0002, 1'b0, 1'b0, 1'b1);
        chk(viol_count, 16'h0001);
        frame(48'h0a0a_0000_0001, 1'b1, 1'b0, 1'b1);
        chk(viol_count, 16'h0002);
        cfg_sticky_en = 1'b1;
        cyc(2);
        cmd(3'h4, 48'h0000_0000_0000, 1'b0, 1'b0);
        chk(entry_count, 8'h01);
        cmd(3'h3, 48'h0000_0000_0000, 1'b0, 1'b0);
        chk(entry_count, 8'h00);
        cmd(3'h0, 48'h0a0a_0000_0003, 1'b1, 1'b1);
        cmd(3'h0, 48'h0a0a_0000_0003, 1'b0, 1'b0);
        chk(entry_count, 8'h01);
        cmd(3'h0, 48'h0a0a_0000_0004, 1'b0, 1'b1);
        cmd(3'h5, 48'h0a0a_0000_0004, 1'b0, 1'b1);
        chk(entry_count, 8'h01);
        // unused mode code must act as shutdown
        cfg_mode = 2'h3;
        frame(48'h0a0a_0000_0002, 1'b0, 1'b0, 1'b1);
        chk({err_disabled, port_led, viol_count}, 18'h2_0003);
        frame(48'h0a0a_0000_0003, 1'b0, 1'b0, 1'b0);
        admin_down = 1'b1;
        cyc(2);
        admin_down = 1'b0;
        cyc(2);
        chk({err_disabled, port_led}, 2'b01);
        cfg_mode = 2'h0;
        frame(48'h0a0a_0000_0005, 1'b0, 1'b0, 1'b1);
        chk({err_disabled, port_led, viol_count}, 18'h2_0004);
        rec_req = 1'b1;
        cyc(2);
        chk(err_disabled, 1'b1);
        rec_en = 1'b1;
        cyc(2);
        chk({err_disabled, port_led}, 2'b01);
        {rec_en, rec_req} = 2'b00;
        cfg_limit = 8'h02;
        pool_other = 11'h3ff;
        cmd(3'h0, 48'h0a0a_0000_0004, 1'b0, 1'b1);
        pool_other = 11'h000;
        cmd(3'h0, 48'h0a0a_0000_0004, 1'b0, 1'b0);
        cfg_limit = 8'h04;
        stim_voice = 1'b1;
        frame(48'h0a0a_0000_0006, 1'b0, 1'b1, 1'b0);
        stim_voice = 1'b0;
        frame(48'h0a0a_0000_0006, 1'b0, 1'b1, 1'b0);
        cyc(1);
        chk(entry_count, 8'h04);
        cmd(3'h4, 48'h0000_0000_0000, 1'b0, 1'b0);
        chk(entry_count, 8'h03);
        for (int k = 0; k < 4; k++) begin
            inel = 4'h1 << k;
            cyc(2);
            chk({guard_refused, guard_active}, 2'b10);
        end
        print_verdict();
    end
endmodule : psg_guard_tb_top
`default_nettype wire
